// File: aio_pkg.sv
// Constants and types shared by the analog I/O event and fault logic
package aio_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int AIO_NCH = 4;
    localparam int AIO_NAO = 4;
    localparam int AIO_NERR = 4;
    localparam int AIO_DW = 16;
    localparam int AIO_AW = 24;
    localparam int AIO_CW = 2;
    localparam int AIO_SW = AIO_NCH + 1;
    localparam int AIO_STAT_ERR = AIO_NCH;
    // ------------------------------------------------------------
    // Object indexes, address is {index, sub-index}
    // ------------------------------------------------------------
    localparam logic [15:0] AIO_OBJ_AIN = 16'h6401;
    localparam logic [15:0] AIO_OBJ_AOUT = 16'h6411;
    localparam logic [15:0] AIO_OBJ_TRIG = 16'h6421;
    localparam logic [15:0] AIO_OBJ_GEN = 16'h6423;
    localparam logic [15:0] AIO_OBJ_UPPER = 16'h6424;
    localparam logic [15:0] AIO_OBJ_LOWER = 16'h6425;
    localparam logic [15:0] AIO_OBJ_DELTA = 16'h6426;
    localparam logic [15:0] AIO_OBJ_NEGD = 16'h6427;
    localparam logic [15:0] AIO_OBJ_POSD = 16'h6428;
    localparam logic [15:0] AIO_OBJ_EMODE = 16'h6443;
    localparam logic [15:0] AIO_OBJ_EVAL = 16'h6444;
    localparam logic [15:0] AIO_OBJ_IRQ_STAT = 16'h5F00;
    localparam logic [15:0] AIO_OBJ_IRQ_MASK = 16'h5F01;
    localparam logic [15:0] AIO_OBJ_FAULT = 16'h5F02;
    localparam logic [7:0] AIO_SUB_COUNT = 8'h00;
    // ------------------------------------------------------------
    // Trigger selection bits and reset values
    // ------------------------------------------------------------
    localparam int AIO_TRIG_UPPER = 0;
    localparam int AIO_TRIG_LOWER = 1;
    localparam int AIO_TRIG_DELTA = 2;
    localparam int AIO_TRIG_NEGD = 3;
    localparam int AIO_TRIG_POSD = 4;
    localparam int AIO_TRIG_USED = 5;
    localparam int AIO_EMODE_BIT = 0;
    localparam logic [7:0] AIO_TRIG_RST = 8'h07;
    localparam logic [7:0] AIO_GEN_RST = 8'h00;
    localparam logic [15:0] AIO_LIMIT_RST = 16'h0000;
    localparam logic [15:0] AIO_EMODE_RST = 16'h0001;
    localparam logic [15:0] AIO_EVAL_RST = 16'h0000;
    localparam logic [15:0] AIO_AOUT_RST = 16'h0000;
    localparam logic [AIO_SW-1:0] AIO_MASK_RST = '0;

    typedef logic [AIO_DW-1:0] aio_word_t;
endpackage

// File: aio_chan_if.sv
// Per-channel configuration bundle between the register file and a detector
`timescale 1ns/1ps
`default_nettype none
interface aio_chan_if;
    logic [7:0] trig_sel;
    logic glob_en;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] delta;
    logic [15:0] neg_delta;
    logic [15:0] pos_delta;
    modport cfg (output trig_sel, glob_en, upper, lower, delta, neg_delta, pos_delta);
    modport det (input trig_sel, glob_en, upper, lower, delta, neg_delta, pos_delta);
endinterface
`default_nettype wire

// File: aio_ain_det.sv
// One analog input channel: sample holder, event detector and delta reference
`timescale 1ns/1ps
`default_nettype none
module aio_ain_det
    import aio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    aio_chan_if.det cfg,
    input wire logic strobe,
    input wire logic [15:0] value,
    output logic [15:0] cur,
    output logic [15:0] last_sent,
    output logic fire
);
    logic [16:0] rise;
    logic [16:0] fall;
    logic changed, up_hit, lo_hit, d_hit, n_hit, p_hit;
    logic lim_sel, dlt_sel, lim_ok, dlt_ok, next_fire;

    // ------------------------------------------------------------
    // Conditions, all limits compared on the full left-adjusted word
    // ------------------------------------------------------------
    assign rise = {1'b0, value} - {1'b0, last_sent};
    assign fall = {1'b0, last_sent} - {1'b0, value};
    assign changed = strobe && (value != cur);
    assign up_hit = value >= cfg.upper;
    assign lo_hit = value < cfg.lower;
    assign p_hit = (value > last_sent) && (rise[15:0] > cfg.pos_delta);
    assign n_hit = (value < last_sent) && (fall[15:0] > cfg.neg_delta);
    assign d_hit = (value > last_sent) ? (rise[15:0] > cfg.delta)
                                       : (fall[15:0] > cfg.delta);
    assign lim_sel = cfg.trig_sel[AIO_TRIG_UPPER] | cfg.trig_sel[AIO_TRIG_LOWER];
    assign dlt_sel = |cfg.trig_sel[AIO_TRIG_POSD:AIO_TRIG_DELTA];
    assign lim_ok = (cfg.trig_sel[AIO_TRIG_UPPER] & up_hit)
                  | (cfg.trig_sel[AIO_TRIG_LOWER] & lo_hit);
    assign dlt_ok = (cfg.trig_sel[AIO_TRIG_DELTA] & d_hit)
                  | (cfg.trig_sel[AIO_TRIG_NEGD] & n_hit)
                  | (cfg.trig_sel[AIO_TRIG_POSD] & p_hit);
    // A selected delta must also be met before a limit may fire
    assign next_fire = changed && cfg.glob_en
                     && (lim_sel ? (lim_ok && (!dlt_sel || dlt_ok)) : dlt_ok);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= 16'h0000;
        end else if (strobe) begin
            cur <= value;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_sent <= 16'h0000;
            fire <= 1'b0;
        end else begin
            fire <= next_fire;
            if (next_fire) begin
                last_sent <= value;
            end
        end
    end
endmodule
`default_nettype wire

// File: aio_aout_ch.sv
// One analog output channel with its fault substitution
`timescale 1ns/1ps
`default_nettype none
module aio_aout_ch
    import aio_pkg::*;
#(
    parameter bit HAS_ENTRY = 1'b1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_value,
    input wire logic err_enter,
    input wire logic err_mode,
    input wire logic [15:0] err_value,
    output logic [15:0] value
);
    // Fault is applied once on entry; later writes are accepted again
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= AIO_AOUT_RST;
        end else if (err_enter && !HAS_ENTRY) begin
            value <= 16'h0000;
        end else if (err_enter && err_mode) begin
            value <= err_value;
        end else if (wr_en) begin
            value <= wr_value;
        end
    end
endmodule
`default_nettype wire

// File: aio_top.sv
// Analog I/O register file, input event detection and output fault logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each analog input is 16 bits; channel 1 is nearest the adapter.
// - Each analog output is 16 bits; channel 1 is nearest the adapter.
// - Trigger bits: upper, lower, delta, negative delta, positive delta; rest reserved.
// - A set trigger bit enables its event; clear bits never interrupt.
// - Without configuration the trigger selection acts at its default value.
// - Global enable gates all input interrupts, masks untouched.
// - After reset no input raises an interrupt until configured.
// - Upper event when input is equal to or above the upper limit.
// - Lower event when input is strictly below the lower limit.
// - Limits are left-adjusted, compared against the full input word.
// - While a limit holds, each input change fires again unless delta also applies.
// - Delta event when input moves beyond delta from last sent value.
// - Negative delta event when input drops beyond it below last sent.
// - Positive delta event when input rises beyond it above last sent.
// - Stop or guard failure is an error; mode-bit outputs take error value.
// - When the error clears, outputs keep their present values.
// - Outputs without an error value entry go to zero on error.
// - Error value applies only when the channel's mode bit is set.
module aio_top
    import aio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [AIO_AW-1:0] bus_addr,
    input wire logic [AIO_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [AIO_DW-1:0] bus_rdata,
    input wire logic [AIO_NCH-1:0][15:0] ain_value,
    input wire logic [AIO_NCH-1:0] ain_strobe,
    input wire logic nmt_stopped,
    input wire logic guard_failed,
    output logic [AIO_NCH-1:0] ain_event,
    output logic [AIO_NCH-1:0][15:0] ain_sent,
    output logic [AIO_NAO-1:0][15:0] aout_value,
    output logic fault_active,
    output logic irq
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [AIO_NCH-1:0][7:0] trig_sel;
    logic [7:0] glob_en;
    logic [AIO_NCH-1:0][15:0] upper;
    logic [AIO_NCH-1:0][15:0] lower;
    logic [AIO_NCH-1:0][15:0] delta;
    logic [AIO_NCH-1:0][15:0] neg_delta;
    logic [AIO_NCH-1:0][15:0] pos_delta;
    logic [AIO_NAO-1:0][15:0] err_mode;
    logic [AIO_NERR-1:0][15:0] err_value;
    logic [AIO_SW-1:0] irq_stat;
    logic [AIO_SW-1:0] irq_mask;
    logic [AIO_NCH-1:0][15:0] ain_cur;
    logic fault_q;
    logic err_now;
    logic err_enter;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [15:0] obj;
    logic [7:0] sub;
    logic [7:0] sidx;
    logic in_ch;
    logic in_ao;
    logic in_ev;
    logic [AIO_CW-1:0] ci;
    logic [AIO_NAO-1:0] aout_wr;

    assign obj = bus_addr[23:8];
    assign sub = bus_addr[7:0];
    assign sidx = sub - 8'h01;
    assign ci = sidx[AIO_CW-1:0];
    assign in_ch = (sub != AIO_SUB_COUNT) && (sub <= 8'(AIO_NCH));
    assign in_ao = (sub != AIO_SUB_COUNT) && (sub <= 8'(AIO_NAO));
    assign in_ev = (sub != AIO_SUB_COUNT) && (sub <= 8'(AIO_NERR));

    // ------------------------------------------------------------
    // Input configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < AIO_NCH; i++) begin
                trig_sel[i] <= AIO_TRIG_RST;
                upper[i] <= AIO_LIMIT_RST;
                lower[i] <= AIO_LIMIT_RST;
                delta[i] <= AIO_LIMIT_RST;
                neg_delta[i] <= AIO_LIMIT_RST;
                pos_delta[i] <= AIO_LIMIT_RST;
            end
        end else if (bus_wr && in_ch) begin
            for (int i = 0; i < AIO_NCH; i++) begin
                if (sub == 8'(i + 1)) begin
                    case (obj)
                        AIO_OBJ_TRIG: begin
                            // Reserved selection bits stay zero
                            trig_sel[i] <= {3'b000, bus_wdata[AIO_TRIG_USED-1:0]};
                        end
                        AIO_OBJ_UPPER: upper[i] <= bus_wdata;
                        AIO_OBJ_LOWER: lower[i] <= bus_wdata;
                        AIO_OBJ_DELTA: delta[i] <= bus_wdata;
                        AIO_OBJ_NEGD: neg_delta[i] <= bus_wdata;
                        AIO_OBJ_POSD: pos_delta[i] <= bus_wdata;
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            glob_en <= AIO_GEN_RST;
        end else if (bus_wr && obj == AIO_OBJ_GEN && sub == AIO_SUB_COUNT) begin
            glob_en <= {7'h00, bus_wdata[0]};
        end
    end

    // ------------------------------------------------------------
    // Output fault configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < AIO_NAO; i++) begin
                err_mode[i] <= AIO_EMODE_RST;
            end
            for (int i = 0; i < AIO_NERR; i++) begin
                err_value[i] <= AIO_EVAL_RST;
            end
        end else if (bus_wr) begin
            for (int i = 0; i < AIO_NAO; i++) begin
                if (obj == AIO_OBJ_EMODE && in_ao && sub == 8'(i + 1)) begin
                    err_mode[i] <= bus_wdata;
                end
            end
            for (int i = 0; i < AIO_NERR; i++) begin
                if (obj == AIO_OBJ_EVAL && in_ev && sub == 8'(i + 1)) begin
                    err_value[i] <= bus_wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    // Both causes come from the adapter's own state logic on this clock
    assign err_now = nmt_stopped | guard_failed;
    assign err_enter = err_now && !fault_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= err_now;
        end
    end

    assign fault_active = fault_q;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [AIO_SW-1:0] stat_set;
    logic [AIO_SW-1:0] stat_clr;

    assign stat_set = {err_enter, ain_event};
    assign stat_clr = (bus_wr && obj == AIO_OBJ_IRQ_STAT && sub == AIO_SUB_COUNT)
                    ? bus_wdata[AIO_SW-1:0] : '0;

    // A new event in the clearing cycle is kept
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= AIO_MASK_RST;
        end else if (bus_wr && obj == AIO_OBJ_IRQ_MASK && sub == AIO_SUB_COUNT) begin
            irq_mask <= bus_wdata[AIO_SW-1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Input channels, index 0 is sub-index 1 nearest the adapter
    // ------------------------------------------------------------
    for (genvar g = 0; g < AIO_NCH; g++) begin : g_ain
        aio_chan_if u_cfg ();
        assign u_cfg.trig_sel = trig_sel[g];
        assign u_cfg.glob_en = glob_en[0];
        assign u_cfg.upper = upper[g];
        assign u_cfg.lower = lower[g];
        assign u_cfg.delta = delta[g];
        assign u_cfg.neg_delta = neg_delta[g];
        assign u_cfg.pos_delta = pos_delta[g];

        aio_ain_det u_det (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .cfg(u_cfg.det),
            .strobe(ain_strobe[g]),
            .value(ain_value[g]),
            .cur(ain_cur[g]),
            .last_sent(ain_sent[g]),
            .fire(ain_event[g])
        );
    end

    // ------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < AIO_NAO; g++) begin : g_aout
        localparam bit HAS = (g < AIO_NERR);
        logic [15:0] ev;
        if (HAS) begin : g_ev
            assign ev = err_value[g];
        end else begin : g_noev
            assign ev = 16'h0000;
        end
        assign aout_wr[g] = bus_wr && obj == AIO_OBJ_AOUT && in_ao && sub == 8'(g + 1);

        aio_aout_ch #(
            .HAS_ENTRY(HAS)
        ) u_ch (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .wr_en(aout_wr[g]),
            .wr_value(bus_wdata),
            .err_enter(err_enter),
            .err_mode(err_mode[g][AIO_EMODE_BIT]),
            .err_value(ev),
            .value(aout_value[g])
        );
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the read strobe
    // ------------------------------------------------------------
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (sub == AIO_SUB_COUNT) begin
            case (obj)
                AIO_OBJ_AIN, AIO_OBJ_TRIG, AIO_OBJ_UPPER, AIO_OBJ_LOWER,
                AIO_OBJ_DELTA, AIO_OBJ_NEGD, AIO_OBJ_POSD: next_rdata = 16'(AIO_NCH);
                AIO_OBJ_AOUT, AIO_OBJ_EMODE: next_rdata = 16'(AIO_NAO);
                AIO_OBJ_EVAL: next_rdata = 16'(AIO_NERR);
                AIO_OBJ_GEN: next_rdata = {8'h00, glob_en};
                AIO_OBJ_IRQ_STAT: next_rdata = 16'(irq_stat);
                AIO_OBJ_IRQ_MASK: next_rdata = 16'(irq_mask);
                AIO_OBJ_FAULT: next_rdata = {15'h0000, fault_q};
                default: next_rdata = 16'h0000;
            endcase
        end else begin
            case (obj)
                AIO_OBJ_AIN: next_rdata = in_ch ? ain_cur[ci] : 16'h0000;
                AIO_OBJ_TRIG: next_rdata = in_ch ? {8'h00, trig_sel[ci]} : 16'h0000;
                AIO_OBJ_UPPER: next_rdata = in_ch ? upper[ci] : 16'h0000;
                AIO_OBJ_LOWER: next_rdata = in_ch ? lower[ci] : 16'h0000;
                AIO_OBJ_DELTA: next_rdata = in_ch ? delta[ci] : 16'h0000;
                AIO_OBJ_NEGD: next_rdata = in_ch ? neg_delta[ci] : 16'h0000;
                AIO_OBJ_POSD: next_rdata = in_ch ? pos_delta[ci] : 16'h0000;
                AIO_OBJ_AOUT: next_rdata = in_ao ? aout_value[ci] : 16'h0000;
                AIO_OBJ_EMODE: next_rdata = in_ao ? err_mode[ci] : 16'h0000;
                AIO_OBJ_EVAL: next_rdata = in_ev ? err_value[ci] : 16'h0000;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks on the channels and outputs that carry each setting
    // ------------------------------------------------------------
    AST_GLOBAL_GATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !glob_en[0] |=> (ain_event == '0))
        else $error("event while global enable is off");

    AST_NO_SELECT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (trig_sel[3][4:0] == 5'h00) |=> !ain_event[3])
        else $error("event with empty trigger selection");

    AST_UPPER_HIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (glob_en[0] && trig_sel[0][4:0] == 5'h01 && ain_strobe[0]
         && ain_value[0] != ain_cur[0] && ain_value[0] >= upper[0]) |=> ain_event[0])
        else $error("upper limit event missing");

    AST_LOWER_EDGE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (trig_sel[1][4:0] == 5'h02 && ain_value[1] == lower[1]) |=> !ain_event[1])
        else $error("lower limit fired at equal value");

    AST_POS_DELTA: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (glob_en[0] && trig_sel[2][4:0] == 5'h10 && ain_strobe[2]
         && ain_value[2] > ain_sent[2]
         && 17'(ain_value[2]) - 17'(ain_sent[2]) > 17'(pos_delta[2])) |=> ain_event[2])
        else $error("positive delta event missing");

    AST_REF_UPDATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ain_event[0] |-> (ain_sent[0] == ain_cur[0]) ##1 $stable(ain_sent[0]) || ain_event[0])
        else $error("reference not taken from sent value");

    AST_ERR_VALUE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (err_enter && err_mode[0][AIO_EMODE_BIT]) |=> (aout_value[0] == $past(err_value[0])))
        else $error("output did not take error value");

    AST_ERR_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (err_enter && !err_mode[1][AIO_EMODE_BIT]) |=> $stable(aout_value[1]))
        else $error("output changed without error mode");

    AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fault_q && !err_now && !aout_wr[0]) |=> $stable(aout_value[0]))
        else $error("output restored on error clear");

    AST_NEG_DELTA: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (glob_en[0] && trig_sel[2][4:0] == 5'h08 && ain_strobe[2] && ain_value[2] < ain_sent[2]
         && 17'(ain_sent[2]) - 17'(ain_value[2]) > 17'(neg_delta[2])) |=> ain_event[2])
        else $error("negative delta event missing");

    AST_ERR_STATUS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        stat_set[AIO_STAT_ERR] |=> irq_stat[AIO_STAT_ERR])
        else $error("fault entry not recorded in status");
endmodule
`default_nettype wire

// File: aio_exp_model.sv
// Behavioural expansion analog modules feeding sampled input words
`timescale 1ns/1ps
`default_nettype none
module aio_exp_model
    import aio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic req,
    input wire logic [1:0] req_ch,
    input wire logic [15:0] req_val,
    output logic [AIO_NCH-1:0][15:0] ain_value,
    output logic [AIO_NCH-1:0] ain_strobe
);
    initial begin
        ain_value = '0;
        ain_strobe = '0;
    end
    // Words toggle outside a strobe so stale data is never trusted
    always @(posedge ref_clk) begin
        ain_value <= ~ain_value;
        ain_strobe <= '0;
        if (req) begin
            ain_value[req_ch] <= req_val;
            ain_strobe[req_ch] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: aio_top_tb.sv
// Self-checking bench for the analog I/O event and fault logic
`timescale 1ns/1ps
`default_nettype none
module aio_top_tb;
    import aio_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [AIO_AW-1:0] bus_addr = '0;
    logic [AIO_DW-1:0] bus_wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic nmt_stopped = 1'b0;
    logic guard_failed = 1'b0;
    logic req = 1'b0;
    logic [1:0] req_ch = '0;
    logic [15:0] req_val = '0;
    logic [AIO_DW-1:0] bus_rdata;
    logic [AIO_NCH-1:0][15:0] ain_value, ain_sent;
    logic [AIO_NAO-1:0][15:0] aout_value;
    logic [AIO_NCH-1:0] ain_strobe, ain_event;
    logic fault_active, irq;
    int miscompares = 0;
    int n_tests = 0;
    always #10 ref_clk = ~ref_clk;
    aio_top i_aio_top (.ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .ain_value(ain_value), .ain_strobe(ain_strobe), .nmt_stopped(nmt_stopped),
        .guard_failed(guard_failed), .ain_event(ain_event), .ain_sent(ain_sent),
        .aout_value(aout_value), .fault_active(fault_active), .irq(irq));
    aio_exp_model i_aio_exp_model (.ref_clk(ref_clk), .req(req), .req_ch(req_ch),
        .req_val(req_val), .ain_value(ain_value), .ain_strobe(ain_strobe));
    // ----------------------------------------
    // Bus and sample tasks
    // ----------------------------------------
    task automatic chk(input string s, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [23:0] a, input logic [15:0] exp, input string s);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        chk(s, bus_rdata, exp);
    endtask
    task automatic smp(input int ch, input logic [15:0] v, input logic ev);
        @(posedge ref_clk);
        req <= 1'b1;
        req_ch <= 2'(ch);
        req_val <= v;
        @(posedge ref_clk);
        req <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("event", 16'(ain_event[ch]), 16'(ev));
        if (ev) chk("sent", ain_sent[ch], v);
    endtask
    task automatic t_reset();
        rdc(24'h642101, 16'h0007, "trig");
        rdc(24'h642300, 16'h0000, "gen");
        rdc(24'h644301, 16'h0001, "mode");
        rdc(24'h642100, 16'h0004, "count");
        rdc(24'h123400, 16'h0000, "unmapped");
        rdc(24'h642300, 16'h0000, "gen");
        @(posedge ref_clk);
        #1;
        chk("rdata idle", bus_rdata, 16'h0000);
        smp(3, 16'h9000, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_limits();
        wr(24'h642300, 16'h0001);
        wr(24'h642401, 16'h7000);
        wr(24'h642101, 16'h00FF);
        rdc(24'h642101, 16'h001F, "trig");
        wr(24'h642101, 16'h0001);
        smp(0, 16'h8000, 1'b1);
        smp(0, 16'h7000, 1'b1);
        smp(0, 16'h7000, 1'b0);
        smp(0, 16'h6FFF, 1'b0);
        wr(24'h642300, 16'h0000);
        smp(0, 16'hF000, 1'b0);
        rdc(24'h642101, 16'h0001, "trig");
        wr(24'h642300, 16'h0001);
        smp(0, 16'hF001, 1'b1);
        wr(24'h642104, 16'h0000);
        smp(3, 16'hA000, 1'b0);
        wr(24'h640101, 16'h0000);
        rdc(24'h640101, 16'hF001, "ain");
        wr(24'h642502, 16'h1000);
        wr(24'h642102, 16'h0002);
        smp(1, 16'h0FFF, 1'b1);
        smp(1, 16'h1000, 1'b0);
        smp(1, 16'h0005, 1'b1);
        $display("limit test done");
    endtask
    task automatic t_delta();
        wr(24'h642103, 16'h0004);
        wr(24'h642603, 16'h0100);
        smp(2, 16'h0100, 1'b0);
        smp(2, 16'h0101, 1'b1);
        smp(2, 16'h0001, 1'b0);
        smp(2, 16'h0000, 1'b1);
        wr(24'h642103, 16'h0010);
        wr(24'h642803, 16'h0010);
        smp(2, 16'h0010, 1'b0);
        smp(2, 16'h0011, 1'b1);
        wr(24'h642103, 16'h0008);
        wr(24'h642703, 16'h0010);
        smp(2, 16'h0001, 1'b0);
        smp(2, 16'h0000, 1'b1);
        smp(2, 16'h0050, 1'b0);
        $display("delta test done");
    endtask
    task automatic t_fault();
        wr(24'h641101, 16'h1234);
        wr(24'h641102, 16'h2222);
        wr(24'h641103, 16'h3333);
        wr(24'h644401, 16'h5555);
        wr(24'h644302, 16'h0000);
        @(posedge ref_clk);
        nmt_stopped <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("aout0", aout_value[0], 16'h5555);
        chk("aout1", aout_value[1], 16'h2222);
        chk("aout2", aout_value[2], 16'h0000);
        chk("fault", 16'(fault_active), 16'h0001);
        @(posedge ref_clk);
        nmt_stopped <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("kept", aout_value[0], 16'h5555);
        chk("fault clear", 16'(fault_active), 16'h0000);
        wr(24'h641101, 16'h0AAA);
        guard_failed <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("guard", aout_value[0], 16'h5555);
        $display("fault test done");
    endtask
    task automatic t_irq();
        chk("irq", 16'(irq), 16'h0000);
        rdc(24'h5F0000, 16'h0017, "status");
        wr(24'h5F0100, 16'h0010);
        #1;
        chk("irq", 16'(irq), 16'h0001);
        wr(24'h5F0000, 16'h0017);
        #1;
        chk("irq", 16'(irq), 16'h0000);
        rdc(24'h5F0000, 16'h0000, "status");
        $display("irq test done");
    endtask
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_limits();
        t_delta();
        t_fault();
        t_irq();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
